// ### pkg/cascade_timer_pkg.sv
// Package: types and constants for the cascaded 32-bit up/down timer.
// Assumes one 50 MHz clock and an asynchronous active-low reset.
package cascade_timer_pkg;

	localparam int HALF_W = 16;
	localparam int FULL_W = 32;
	localparam logic [HALF_W-1:0] HALF_RESET = 16'h0000;
	localparam logic [FULL_W-1:0] PERIOD_RESET = 32'hFFFFFFFF;

	// Run state of the 32-bit counter
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_COUNT,
		ST_SATURATED
	} run_state_t;

	// Live count split into the two timer halves
	typedef struct packed {
		logic [HALF_W-1:0] high_half;
		logic [HALF_W-1:0] low_half;
	} count_pair_t;

	// Control inputs from same-clock logic outside the timer
	typedef struct packed {
		logic cascade_enable;
		logic run;
		logic [FULL_W-1:0] period;
	} timer_ctrl_t;

endpackage : cascade_timer_pkg

// ### logic/direction_sync.sv
// Two-flop synchroniser for the direction pin with a change detector.
// Assumes the pin is asynchronous to sys_clk.
`timescale 1ns/1ns
module direction_sync (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic pin_async,
	output logic level,
	output logic changed
);

	logic meta_reg;
	logic level_reg;
	logic prev_reg;

	// Reset to the up level: no false edge, no down start
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_reg <= 1'b1;
			level_reg <= 1'b1;
		end else begin
			meta_reg <= pin_async;
			level_reg <= meta_reg;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			prev_reg <= 1'b1;
		end else begin
			prev_reg <= level_reg;
		end
	end

	assign level = level_reg;
	assign changed = level_reg ^ prev_reg;

endmodule : direction_sync

// ### logic/cascaded_updown_timer32.sv
// Cascaded 32-bit up/down timer built from two 16-bit halves.
// Assumes control comes from same-clock logic; direction pin is asynchronous.
//
// Function
// - Two 16-bit timers join into one counter
// - Counting up saturates at period, no wrap
// - Only a direction pin change, or clearing run or cascade_enable, restarts
// - A pin-change restart counts in the opposite direction; other restarts take the synced pin
// - Counting down stops and holds at zero
// - Halves are live, no shadow register
`timescale 1ns/1ns
module cascaded_updown_timer32 (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire cascade_timer_pkg::timer_ctrl_t ctrl,
	input wire logic count_direction_pin,
	output cascade_timer_pkg::count_pair_t count,
	output logic saturated,
	output logic counting_up
);

	logic dir_level;
	logic dir_changed;
	logic [cascade_timer_pkg::FULL_W-1:0] count_reg;
	logic [cascade_timer_pkg::FULL_W-1:0] count_next;
	logic up_reg;
	logic up_next;
	logic sat_reg;
	cascade_timer_pkg::run_state_t state_reg;
	cascade_timer_pkg::run_state_t state_next;
	cascade_timer_pkg::count_pair_t count_out_reg;
	logic sat_out_reg;
	logic up_out_reg;

	direction_sync u_dir_sync (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.pin_async(count_direction_pin),
		.level(dir_level),
		.changed(dir_changed)
	);

	function automatic logic at_limit(
		input logic up,
		input logic [cascade_timer_pkg::FULL_W-1:0] value,
		input logic [cascade_timer_pkg::FULL_W-1:0] period
	);
		at_limit = up ? (value >= period) : (value == '0);
	endfunction : at_limit

	// Next state and count
	always_comb begin
		state_next = state_reg;
		count_next = count_reg;
		up_next = up_reg;
		if (!ctrl.cascade_enable || !ctrl.run) begin
			state_next = cascade_timer_pkg::ST_IDLE;
			up_next = dir_level;
		end else begin
			unique case (state_reg)
				// Direction taken from the synced pin at start
				cascade_timer_pkg::ST_IDLE: begin
					state_next = cascade_timer_pkg::ST_COUNT;
					up_next = dir_level;
				end
				cascade_timer_pkg::ST_COUNT: begin
					if (at_limit(up_reg, count_reg, ctrl.period)) begin
						state_next = cascade_timer_pkg::ST_SATURATED;
					end else if (up_reg) begin
						count_next = count_reg + 32'h00000001;
					end else begin
						count_next = count_reg - 32'h00000001;
					end
				end
				cascade_timer_pkg::ST_SATURATED: begin
					if (dir_changed) begin
						state_next = cascade_timer_pkg::ST_COUNT;
						up_next = ~up_reg;
					end
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= cascade_timer_pkg::ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			count_reg <= {cascade_timer_pkg::HALF_RESET, cascade_timer_pkg::HALF_RESET};
		end else begin
			count_reg <= count_next;
		end
	end

	// Up is the default direction out of reset
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			up_reg <= 1'b1;
		end else begin
			up_reg <= up_next;
		end
	end

	assign sat_reg = (state_reg == cascade_timer_pkg::ST_SATURATED);

	// Halves copied live every cycle, no snapshot
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			count_out_reg <= '0;
			sat_out_reg <= 1'b0;
			up_out_reg <= 1'b1;
		end else begin
			count_out_reg.high_half <= count_next[31:16];
			count_out_reg.low_half <= count_next[15:0];
			sat_out_reg <= (state_next == cascade_timer_pkg::ST_SATURATED);
			up_out_reg <= up_next;
		end
	end

	assign count = count_out_reg;
	assign saturated = sat_out_reg;
	assign counting_up = up_out_reg;

	sequence seq_saturated_no_change;
		sat_reg && !dir_changed && ctrl.run && ctrl.cascade_enable;
	endsequence

	sequence seq_restart;
		sat_reg && dir_changed && ctrl.run && ctrl.cascade_enable;
	endsequence

	AST_SAT_HOLDS: assert property (@(posedge sys_clk) disable iff (!reset_n)
		seq_saturated_no_change |=> $stable(count_reg) && sat_reg)
		else $error("Saturated counter moved without direction change");

	AST_RESTART_FLIPS: assert property (@(posedge sys_clk) disable iff (!reset_n)
		seq_restart |=> (up_reg != $past(up_reg)) && !sat_reg)
		else $error("Restart did not reverse direction");

	AST_UP_NO_WRAP: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(state_reg == cascade_timer_pkg::ST_COUNT) && up_reg && count_reg >= ctrl.period
		&& ctrl.run && ctrl.cascade_enable |=> sat_reg && $stable(count_reg))
		else $error("Up count passed period");

	AST_DOWN_ZERO: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(state_reg == cascade_timer_pkg::ST_COUNT) && !up_reg && count_reg == '0
		&& ctrl.run && ctrl.cascade_enable |=> sat_reg && count_reg == '0)
		else $error("Down count passed zero");

	AST_STEP_ONE: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(state_reg == cascade_timer_pkg::ST_COUNT) && up_reg && count_reg < ctrl.period
		&& ctrl.run && ctrl.cascade_enable |=> count_reg == $past(count_reg) + 32'h00000001)
		else $error("Up step not one");

	AST_LIVE_HALVES: assert property (@(posedge sys_clk) disable iff (!reset_n)
		1'b1 |-> {count.high_half, count.low_half} == count_reg)
		else $error("Output halves not live");

	AST_SYNC_CHANGE: assert property (@(posedge sys_clk) disable iff (!reset_n)
		dir_changed |-> dir_level != $past(dir_level))
		else $error("Change flag without level change");

	AST_SAT_OUT: assert property (@(posedge sys_clk) disable iff (!reset_n)
		saturated == sat_reg)
		else $error("Saturated output mismatch");

	sequence seq_left_saturation;
		sat_reg ##1 (state_reg == cascade_timer_pkg::ST_COUNT);
	endsequence

	sequence seq_stopped;
		!ctrl.run || !ctrl.cascade_enable;
	endsequence

	AST_LEAVE_SAT: assert property (@(posedge sys_clk) disable iff (!reset_n)
		seq_left_saturation |-> $past(dir_changed))
		else $error("Saturation left without direction change");

	AST_STOP_FREEZE: assert property (@(posedge sys_clk) disable iff (!reset_n)
		seq_stopped |=> $stable(count_reg) && !sat_reg)
		else $error("Stopped counter moved");

	AST_STEP_DOWN: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(state_reg == cascade_timer_pkg::ST_COUNT) && !up_reg && count_reg != '0
		&& ctrl.run && ctrl.cascade_enable |=> count_reg == $past(count_reg) - 32'h00000001)
		else $error("Down step not one");

	AST_HOLD_IDLE: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(state_reg != cascade_timer_pkg::ST_COUNT) |=> $stable(count_reg))
		else $error("Count moved outside counting state");

	AST_DIR_FIXED: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(state_reg == cascade_timer_pkg::ST_COUNT) && ctrl.run && ctrl.cascade_enable
		|=> up_reg == $past(up_reg))
		else $error("Direction changed while counting");

	AST_LOAD_DIR: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(state_reg == cascade_timer_pkg::ST_IDLE) || !ctrl.run || !ctrl.cascade_enable
		|=> up_reg == $past(dir_level))
		else $error("Start direction not taken from pin");

	// Skips three edges after reset while the flops refill
	AST_SYNC_PIN: assert property (@(posedge sys_clk) disable iff (!reset_n)
		$past(reset_n, 3) && $past(reset_n, 2) && $past(reset_n)
		|-> dir_changed == ($past(count_direction_pin, 2) != $past(count_direction_pin, 3)))
		else $error("Change flag does not follow pin");

	AST_UP_TOP: assert property (@(posedge sys_clk) disable iff (!reset_n)
		$rose(sat_reg) && up_reg |-> count_reg >= $past(ctrl.period))
		else $error("Up saturation below period");

	AST_DOWN_FLOOR: assert property (@(posedge sys_clk) disable iff (!reset_n)
		$rose(sat_reg) && !up_reg |-> count_reg == '0)
		else $error("Down saturation above zero");

endmodule : cascaded_updown_timer32

// ### tb/dir_pin_model.sv
// Direction pin driver standing in for the outside logic.
// Assumes flip is raised for one cycle, off the sampling edge.
`timescale 1ns/1ns
module dir_pin_model (
	input wire logic sys_clk,
	input wire logic flip,
	output logic count_direction_pin
);
	// Up at start
	initial count_direction_pin = 1'b1;
	always @(posedge sys_clk) begin
		if (flip) begin
			count_direction_pin <= ~count_direction_pin;
		end
	end
endmodule : dir_pin_model

// ### tb/cascaded_updown_timer32_tb.sv
// Self-checking bench for the cascaded up/down timer.
// Assumes the pin model drives the direction pin.
`timescale 1ns/1ns
module cascaded_updown_timer32_tb;
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	logic flip = 1'b0;
	logic pin;
	logic saturated;
	logic counting_up;
	cascade_timer_pkg::timer_ctrl_t ctrl = '0;
	cascade_timer_pkg::count_pair_t count;
	logic [31:0] held;
	int failures = 0;
	int checks = 0;
	int cyc = 0;
	logic [31:0] rows [2] = '{32'h00000004, 32'h00000009};
	always #10 sys_clk = ~sys_clk;
	dir_pin_model u_pin (.sys_clk(sys_clk), .flip(flip), .count_direction_pin(pin));
	cascaded_updown_timer32 u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .ctrl(ctrl),
		.count_direction_pin(pin), .count(count), .saturated(saturated),
		.counting_up(counting_up));
	task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s exp %h seen %h", what, exp, seen);
		end
	endtask : chk
	task end_sim;
		if (failures == 0 && checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : end_sim
	task step(input int n);
		repeat (n) @(posedge sys_clk);
		#2;
	endtask : step
	task wait_sat(input logic lvl);
		int k;
		k = 0;
		while (saturated !== lvl && k < 100) begin
			step(1);
			k++;
		end
		chk("saturated", {31'h0, saturated}, {31'h0, lvl});
	endtask : wait_sat
	task toggle;
		flip = 1'b1;
		step(1);
		flip = 1'b0;
	endtask : toggle
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 3000) begin
			failures++;
			end_sim();
		end
	end
	initial begin
		step(4);
		chk("reset count", count, 32'h00000000);
		chk("reset up", {31'h0, counting_up}, 32'h00000001);
		chk("reset sat", {31'h0, saturated}, 32'h00000000);
		reset_n = 1'b1;
		ctrl.cascade_enable = 1'b1;
		for (int i = 0; i < 2; i++) begin
			ctrl.period = rows[i];
			ctrl.run = 1'b1;
			wait_sat(1'b1);
			chk("up limit", count, rows[i]);
			chk("up dir", {31'h0, counting_up}, 32'h00000001);
			step(6);
			chk("held limit", count, rows[i]);
			toggle();
			wait_sat(1'b0);
			chk("down dir", {31'h0, counting_up}, 32'h00000000);
			wait_sat(1'b1);
			chk("down limit", count, 32'h00000000);
			step(6);
			chk("held zero", count, 32'h00000000);
			ctrl.run = 1'b0;
			toggle();
			step(4);
			chk("stop clears sat", {31'h0, saturated}, 32'h00000000);
		end
		// Stop mid-count; the halves freeze and read coherently
		ctrl.period = 32'h00000050;
		ctrl.run = 1'b1;
		step(8);
		ctrl.run = 1'b0;
		step(2);
		held = count;
		step(4);
		chk("stopped count", count, held);
		chk("stopped value", count, 32'h00000007);
		chk("high half", {16'h0, count.high_half}, 32'h00000000);
		chk("low half", {16'h0, count.low_half}, 32'h00000007);
		// Joining off: run alone must not move the count
		ctrl.cascade_enable = 1'b0;
		ctrl.run = 1'b1;
		step(4);
		chk("unjoined hold", count, 32'h00000007);
		ctrl.cascade_enable = 1'b1;
		step(3);
		chk("rejoined count", count, 32'h00000009);
		// Reset in mid-count, then a request at the first edge after release
		reset_n = 1'b0;
		step(1);
		chk("mid reset count", count, 32'h00000000);
		chk("mid reset sat", {31'h0, saturated}, 32'h00000000);
		chk("mid reset up", {31'h0, counting_up}, 32'h00000001);
		reset_n = 1'b1;
		step(3);
		chk("restart count", count, 32'h00000002);
		end_sim();
	end
endmodule : cascaded_updown_timer32_tb
